// *** core/analog_comparator_control.v ***
`timescale 1ns/100ps
`include "comparator_map.vh"

module analog_comparator_control
(
   input  wire        mclk_in,
   input  wire        rst_n_in,
   input  wire [7:0]  addr_in,
   input  wire [31:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [31:0] rdata_out,
   input  wire        wp_in,
   input  wire        dbg_in,
   input  wire [3:0]  cmp_raw_in,
   output wire [3:0]  cmp_en_out,
   output wire [3:0]  hyst_out,
   output wire [3:0]  speed_out,
   output wire [7:0]  muxpos_out,
   output wire [11:0] muxneg_out,
   output wire [23:0] scaler_out,
   output wire [3:0]  pin_out,
   output wire [3:0]  pin_oe_out,
   output reg  [5:0]  event_out,
   output wire        irq_out
);

   // Settle time rounded up to whole clocks; the counter holds at most 255.
   localparam integer SETTLE_FULL = (`SETTLE_NS * `CLK_MHZ + 999) / 1000;
   localparam [7:0]   SETTLE_CYC  = SETTLE_FULL[7:0];

   reg         enable_reg;
   reg  [5:0]  event_control_register_reg;
   reg  [5:0]  irq_en_reg;
   reg  [5:0]  irq_stat_reg;
   reg  [6:0]  winctrl_reg;
   reg  [15:0] cfg_reg [0:3];
   reg  [5:0]  scl_reg [0:3];
   reg  [3:0]  sync1_reg;
   reg  [3:0]  sync2_reg;
   wire [3:0]  win_st;
   wire [3:0]  result;
   wire [3:0]  cmp_irq;
   wire [3:0]  cmp_chg;
   wire [3:0]  busy;
   wire        wr_ok;
   wire        soft_rst;
   wire        clr;
   wire [5:0]  irq_set;
   wire [1:0]  win_irq;
   wire [1:0]  win_chg;
   wire [1:0]  win_on;
   integer     i;

   // ------------------------------------------------------------
   // Bus write qualification
   // ------------------------------------------------------------

   // Protected writes are dropped unless the debugger issues them.
   // debugger bypasses protection
   assign wr_ok = wr_in & (~wp_in | dbg_in);

   // Soft reset acts through the same synchronous clear as the pin.
   // soft reset clear
   assign soft_rst = wr_ok & (addr_in == `A_MAIN_CTRL) & wdata_in[`F_SOFT_RST];
   assign clr      = ~rst_n_in | soft_rst;

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------

   // Register writes; the soft reset bit itself is never stored.
   always @(posedge mclk_in)
   begin
      if (clr)
      begin
         enable_reg  <= 1'b0;
         event_control_register_reg  <= `EV_RST;
         irq_en_reg  <= 6'h00;
         winctrl_reg <= 7'h00;
         for (i = 0; i < 4; i = i + 1)
         begin
            cfg_reg[i] <= `CFG_RST;
            scl_reg[i] <= `SCL_RST;
         end
      end
      else if (wr_ok)
      begin
         if (addr_in == `A_MAIN_CTRL)
            enable_reg <= wdata_in[`F_ENABLE];
         if (addr_in == `A_EVENT_CTRL && !enable_reg)
            event_control_register_reg <= wdata_in[5:0];
         if (addr_in == `A_IRQ_EN)
            irq_en_reg <= wdata_in[5:0];
         if (addr_in == `A_WINCTRL)
            winctrl_reg <= wdata_in[6:0];
         for (i = 0; i < 4; i = i + 1)
         begin
            if (addr_in == `A_CFG0 + 8'h04 * i[7:0])
            begin
               if (cfg_reg[i][`C_EN])
                  cfg_reg[i][`C_EN] <= wdata_in[`C_EN];
               else
                  cfg_reg[i] <= wdata_in[15:0];
            end
            if (addr_in == `A_SCL0 + 8'h04 * i[7:0] && !cfg_reg[i][`C_EN])
               scl_reg[i] <= wdata_in[5:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------

   // Analog results are asynchronous; sync2 feeds all logic except the async pin path, which uses cmp_raw_in.
   always @(posedge mclk_in)
   begin
      if (clr)
      begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end
      else
      begin
         sync1_reg <= cmp_raw_in;
         sync2_reg <= sync1_reg;
      end
   end

   // ------------------------------------------------------------
   // Per-comparator datapath
   // ------------------------------------------------------------

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : comp
         reg  [4:0] hist_reg;
         reg        res_reg;
         reg        busy_reg;
         reg  [7:0] cnt_reg;
         reg        filt;
         wire       en;
         wire       start;
         wire       upd;

         assign en = enable_reg & cfg_reg[g][`C_EN];
         assign start = wr_ok & (addr_in == `A_START) & wdata_in[g];
         // Single shot waits the settle time before sampling.
         // single-shot versus continuous
         assign upd = en & (cfg_reg[g][`C_SINGLE] ?
                            (busy_reg & (cnt_reg == 8'h00)) : 1'b1);

         // Majority vote over recent samples; history restarts on enable,
         // so the first few filtered values lean toward zero.
         // optional majority filter
         always @*
         begin
            case (cfg_reg[g][`C_FILT])
               `FILT_MAJ3:
                  filt = (hist_reg[0] & hist_reg[1]) | (hist_reg[0] & hist_reg[2]) |
                         (hist_reg[1] & hist_reg[2]);
               `FILT_MAJ5:
                  filt = ({2'b00, hist_reg[0]} + {2'b00, hist_reg[1]} +
                          {2'b00, hist_reg[2]} + {2'b00, hist_reg[3]} +
                          {2'b00, hist_reg[4]}) >= 3'd3;
               default:
                  filt = hist_reg[0];
            endcase
         end

         // Result, filter history and single-shot counter.
         always @(posedge mclk_in)
         begin
            if (clr || !en)
            begin
               hist_reg <= 5'h00;
               res_reg  <= 1'b0;
               busy_reg <= 1'b0;
               cnt_reg  <= 8'h00;
            end
            else
            begin
               hist_reg <= {hist_reg[3:0], sync2_reg[g]};
               if (upd)
                  res_reg <= filt;
               if (start && !busy_reg)
               begin
                  busy_reg <= 1'b1;
                  cnt_reg  <= SETTLE_CYC;
               end
               else if (busy_reg)
               begin
                  if (cnt_reg == 8'h00)
                     busy_reg <= 1'b0;
                  else
                     cnt_reg <= cnt_reg - 8'h01;
               end
            end
         end

         assign result[g]  = res_reg;
         assign busy[g]    = busy_reg;
         assign cmp_chg[g] = upd & (filt != res_reg);

         assign cmp_irq[g] =
            (cfg_reg[g][`C_ISEL] == `ISEL_RISE) ? (upd & filt & ~res_reg) :
            (cfg_reg[g][`C_ISEL] == `ISEL_FALL) ? (upd & ~filt & res_reg) :
            (cfg_reg[g][`C_ISEL] == `ISEL_EOC)  ? (upd & cfg_reg[g][`C_SINGLE]) :
                                                  cmp_chg[g];

         // Async mode bypasses the clock entirely for lowest latency.
         // async or sync pin
         assign pin_out[g] = ~cfg_reg[g][`C_OUTEN] ? 1'b0 :
                             cfg_reg[g][`C_OUTSYNC] ? res_reg :
                             (cmp_raw_in[g] & en);
         assign pin_oe_out[g] = cfg_reg[g][`C_OUTEN];

         // Analog controls come straight from the config flops.
         // hysteresis and speed
         assign cmp_en_out[g]        = en;
         assign hyst_out[g]          = cfg_reg[g][`C_HYST];
         assign speed_out[g]         = cfg_reg[g][`C_SPEED];
         assign muxpos_out[2*g+1:2*g] = cfg_reg[g][`C_MUXPOS];
         // negative input select
         // Codes above three pick internal references, decoded on the analog side.
         assign muxneg_out[3*g+2:3*g] = cfg_reg[g][`C_MUXNEG];
         assign scaler_out[6*g+5:6*g] = scl_reg[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // Window function
   // ------------------------------------------------------------

   // The even comparator marks the upper bound, the odd one the lower.
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1)
      begin : win
         reg  [1:0] nst;
         reg  [1:0] st_reg;
         wire [1:0] cond;

         assign win_on[p] = enable_reg & winctrl_reg[4*p];
         assign cond      = winctrl_reg[4*p+2:4*p+1];

         always @*
         begin
            if (result[2*p])
               nst = `WST_ABOVE;
            else if (!result[2*p+1])
               nst = `WST_BELOW;
            else
               nst = `WST_INSIDE;
         end

         always @(posedge mclk_in)
         begin
            if (clr || !win_on[p])
               st_reg <= `WST_INSIDE;
            else
               st_reg <= nst;
         end

         // Each pair owns its state flops, so no array has two writers.
         assign win_st[2*p+1:2*p] = st_reg;

         // Interrupt fires on entry into the selected region.
         // window region interrupt
         assign win_irq[p] = win_on[p] & (nst != st_reg) &
            ((cond == `WC_OUTSIDE) ? (nst != `WST_INSIDE) : (nst == cond));
         assign win_chg[p] = win_on[p] &
            ((nst == `WST_INSIDE) != (st_reg == `WST_INSIDE));
      end
   endgenerate

   // ------------------------------------------------------------
   // Events and interrupts
   // ------------------------------------------------------------

   // Window bits sit above the four comparator bits.
   assign irq_set = {win_irq, cmp_irq};

   // Sticky status; a new event beats a clear in the same cycle.
   always @(posedge mclk_in)
   begin
      if (clr)
         irq_stat_reg <= 6'h00;
      else if (wr_ok && addr_in == `A_IRQ_CLR)
         irq_stat_reg <= (irq_stat_reg & ~wdata_in[5:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end

   // Level output; it drops once every enabled status bit is cleared.
   assign irq_out = |(irq_stat_reg & irq_en_reg);

   // One-cycle event pulses, registered so the outputs are clean.
   // gated event pulses
   always @(posedge mclk_in)
   begin
      if (clr)
         event_out <= 6'h00;
      else
         event_out <= {win_chg, cmp_chg} & event_control_register_reg;
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------

   // Data appear in the cycle after the strobe; unmapped reads are zero.
   always @(posedge mclk_in)
   begin
      if (clr)
         rdata_out <= 32'h0000_0000;
      else if (!rd_in)
         rdata_out <= 32'h0000_0000;
      else
      begin
         case (addr_in)
            `A_MAIN_CTRL:  rdata_out <= {30'h0000_0000, enable_reg, 1'b0};
            `A_EVENT_CTRL: rdata_out <= {26'h000_0000, event_control_register_reg};
            `A_IRQ_EN:   rdata_out <= {26'h000_0000, irq_en_reg};
            `A_IRQ_STAT: rdata_out <= {26'h000_0000, irq_stat_reg};
            `A_STATUS:   rdata_out <= {16'h0000, 4'h0, win_st,
                                       busy, result};
            `A_WINCTRL:  rdata_out <= {25'h000_0000, winctrl_reg};
            `A_CFG0:     rdata_out <= {16'h0000, cfg_reg[0]};
            `A_CFG1:     rdata_out <= {16'h0000, cfg_reg[1]};
            `A_CFG2:     rdata_out <= {16'h0000, cfg_reg[2]};
            `A_CFG3:     rdata_out <= {16'h0000, cfg_reg[3]};
            `A_SCL0:     rdata_out <= {26'h000_0000, scl_reg[0]};
            `A_SCL1:     rdata_out <= {26'h000_0000, scl_reg[1]};
            `A_SCL2:     rdata_out <= {26'h000_0000, scl_reg[2]};
            `A_SCL3:     rdata_out <= {26'h000_0000, scl_reg[3]};
            default:     rdata_out <= 32'h0000_0000;
         endcase
      end
   end

endmodule // analog_comparator_control

// *** core/comparator_map.vh ***
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define A_MAIN_CTRL 8'h00
`define A_START     8'h04
`define A_EVENT_CTRL 8'h08
`define A_IRQ_EN    8'h0C
`define A_IRQ_CLR   8'h10
`define A_IRQ_STAT  8'h14
`define A_STATUS    8'h18
`define A_WINCTRL   8'h1C
`define A_CFG0      8'h20
`define A_CFG1      8'h24
`define A_CFG2      8'h28
`define A_CFG3      8'h2C
`define A_SCL0      8'h30
`define A_SCL1      8'h34
`define A_SCL2      8'h38
`define A_SCL3      8'h3C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define F_SOFT_RST  0
`define F_ENABLE    1
`define C_EN        0
`define C_SINGLE    1
`define C_ISEL      3:2
`define C_SPEED     4
`define C_HYST      5
`define C_OUTEN     6
`define C_OUTSYNC   7
`define C_MUXNEG    10:8
`define C_MUXPOS    13:12
`define C_FILT      15:14
`define W_EN        0
`define W_COND      2:1
`define W1_EN       4
`define W1_COND     6:5

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define CFG_RST     16'h0000
`define SCL_RST     6'h00
`define EV_RST      6'h00
`define ISEL_TOG    2'h0
`define ISEL_RISE   2'h1
`define ISEL_FALL   2'h2
`define ISEL_EOC    2'h3
`define FILT_MAJ3   2'h1
`define FILT_MAJ5   2'h2
`define WST_ABOVE   2'h0
`define WST_INSIDE  2'h1
`define WST_BELOW   2'h2
`define WC_OUTSIDE  2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SETTLE_NS   1000
`define CLK_MHZ     200

`endif

// *** verification/analog_comparator_control_sva.sv ***
`timescale 1ns/100ps
`include "comparator_map.vh"
module comparator_checker
(
   input wire        mclk_in,
   input wire        rst_n_in,
   input wire [7:0]  addr_in,
   input wire [31:0] wdata_in,
   input wire        wr_in,
   input wire        wp_in,
   input wire        dbg_in,
   input wire [3:0]  cmp_en_out,
   input wire [3:0]  hyst_out,
   input wire [3:0]  speed_out,
   input wire [7:0]  muxpos_out,
   input wire [11:0] muxneg_out,
   input wire [23:0] scaler_out,
   input wire [3:0]  pin_out,
   input wire [3:0]  pin_oe_out,
   input wire [5:0]  event_out,
   input wire        irq_out
);
   // ----------------------------------------------------------------
   // Port checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   // A write only lands when protection is off or the debugger makes it.
   wire wr_ok = wr_in && (!wp_in || dbg_in);
   a_soft_reset: assert property (wr_ok && addr_in == `A_MAIN_CTRL && wdata_in[`F_SOFT_RST] |=>
      cmp_en_out == 4'h0 && pin_oe_out == 4'h0 && scaler_out == 24'h0 && event_out == 6'h0
      && !irq_out) else $error("soft reset left state behind");
   a_unit_off: assert property (wr_ok && addr_in == `A_MAIN_CTRL && !wdata_in[1] |=>
      cmp_en_out == 4'h0) else $error("unit stayed on after disable");
   a_enable_cause: assert property ($rose(cmp_en_out[0]) |-> $past(wr_ok))
      else $error("comparator enabled without a write");
   a_write_guard: assert property (wr_in && wp_in && !dbg_in |=> $stable(cmp_en_out)
      && $stable(hyst_out) && $stable(scaler_out) && $stable(pin_oe_out))
      else $error("protected write changed state");
   a_cfg_frozen: assert property (wr_in && addr_in[7:4] == 4'h2
      && cmp_en_out[addr_in[3:2]] |=> $stable(hyst_out) && $stable(speed_out)
      && $stable(muxpos_out) && $stable(muxneg_out) && $stable(pin_oe_out))
      else $error("settings changed while enabled");
   a_scaler_frozen: assert property (wr_in && addr_in[7:4] == 4'h3
      && cmp_en_out[addr_in[3:2]] |=> $stable(scaler_out))
      else $error("scaler changed while enabled");
   a_irq_mask: assert property (wr_ok && addr_in == `A_IRQ_EN && wdata_in[5:0] == 6'h00
      |=> !irq_out) else $error("interrupt high while all masked");
   a_pin_quiet: assert property (!cmp_en_out[0] [*3] |-> !pin_out[0])
      else $error("pin driven high by a disabled comparator");
   c_soft_reset: cover property (wr_ok && addr_in == `A_MAIN_CTRL && wdata_in[`F_SOFT_RST]);
   c_irq_rise: cover property ($rose(irq_out));
   c_win_event: cover property (event_out[4]);
endmodule // comparator_checker

bind analog_comparator_control comparator_checker u_chk
(
   .mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .wp_in, .dbg_in, .cmp_en_out, .hyst_out,
   .speed_out, .muxpos_out, .muxneg_out, .scaler_out, .pin_out, .pin_oe_out, .event_out, .irq_out
);

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
`include "comparator_map.vh"
module tb_top;
   reg         mclk_in    = 1'b0;
   reg         rst_n_in   = 1'b0;
   reg  [7:0]  addr_in    = 8'h00;
   reg  [31:0] wdata_in   = 32'h0000_0000;
   reg         wr_in      = 1'b0;
   reg         rd_in      = 1'b0;
   reg         wp_in      = 1'b0;
   reg         dbg_in     = 1'b0;
   reg  [3:0]  cmp_raw_in = 4'h0;
   reg  [5:0]  ev_seen    = 6'h00;
   reg  [31:0] c;
   wire [31:0] rdata_out;
   wire [3:0]  cmp_en_out, hyst_out, speed_out, pin_out, pin_oe_out;
   wire [7:0]  muxpos_out;
   wire [11:0] muxneg_out;
   wire [23:0] scaler_out;
   wire [5:0]  event_out;
   wire        irq_out;
   int         n_fail = 0;
   int         check_count = 0;
   int         m[16];
   int         msk[16] = '{2, 0, 'h3f, 'h3f, 0, 0, 0, 'h77, 'hf7ff, 'hf7ff, 'hf7ff, 'hf7ff,
                           'h3f, 'h3f, 'h3f, 'h3f};

   analog_comparator_control DUT
   (
      .mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .wp_in, .dbg_in,
      .cmp_raw_in, .cmp_en_out, .hyst_out, .speed_out, .muxpos_out, .muxneg_out, .scaler_out,
      .pin_out, .pin_oe_out, .event_out, .irq_out
   );

   // Clock; events are gathered mid-cycle so clearing never races the edge.
   always #2.5 mclk_in = ~mclk_in;
   always @(negedge mclk_in) ev_seen = ev_seen | event_out;

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One bus write, then the register model follows what should land.
   task wr(input [7:0] a, input [31:0] d, input p = 1'b0, input g = 1'b0);
      int i;
      i = a >> 2;
      addr_in  <= a;
      wdata_in <= d;
      wp_in    <= p;
      dbg_in   <= g;
      wr_in    <= 1'b1;
      @(posedge mclk_in);
      wr_in    <= 1'b0;
      @(posedge mclk_in);
      if (p && !g || i > 15 || i == 2 && m[0][1])
         return;
      if (i == 0 && d[0])
         m = '{default: 0};
      else if (i < 12 || !m[i - 4][0])
         m[i] = (i > 7 && m[i][0] ? m[i] & ~1 | d & 1 : d) & msk[i];
   endtask

   // One bus read; a negative expectation means the model's value.
   task rd(input [7:0] a, input int e = -1);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge mclk_in);
      rd_in   <= 1'b0;
      #1;
      check("rdata", rdata_out, e < 0 ? (a < 64 ? m[a >> 2] : 0) : e);
      @(posedge mclk_in);
   endtask

   task tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask

   task regs_check;
      for (int a = 0; a < 72; a += 4)
         if (a != 'h18)
            rd(a);
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      c = $urandom(32'h0000_03d7);
      repeat (6) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      regs_check;
      $display("test reset done");
      for (int n = 0; n < 4; n++)
      begin
         c = $urandom & 32'h003f_f7fe;
         wr(`A_CFG0 + 4 * n, 'hffff, 1'b1);
         wr(`A_CFG0 + 4 * n, c, 1'b1, 1'b1);
         wr(`A_SCL0 + 4 * n, c >> 16);
         rd(`A_CFG0 + 4 * n);
         rd(`A_SCL0 + 4 * n);
         check("cfg_ports", {hyst_out[n], speed_out[n], pin_oe_out[n], muxpos_out[2 * n +: 2],
            muxneg_out[3 * n +: 3], scaler_out[6 * n +: 6]}, {c[5:4], c[6], c[13:12], c[10:8], c[21:16]});
      end
      $display("test config done");
      for (int n = 0; n < 4; n++)
         wr(`A_CFG0 + 4 * n, m[8 + n] | 1);
      wr(`A_MAIN_CTRL, 2);
      check("cmp_en", cmp_en_out, 4'hf);
      wr(`A_EVENT_CTRL, 'h3f);
      rd(`A_EVENT_CTRL);
      // Settings are rewritten while every comparator still runs.
      for (int n = 0; n < 4; n++)
      begin
         wr(`A_SCL0 + 4 * n, 'h3f);
         wr(`A_CFG0 + 4 * n, 'hffff);
         rd(`A_SCL0 + 4 * n);
         rd(`A_CFG0 + 4 * n);
      end
      wr(`A_MAIN_CTRL, 0);
      check("cmp_off", cmp_en_out, 4'h0);
      wr(`A_EVENT_CTRL, 'h3f);
      rd(`A_EVENT_CTRL);
      $display("test freeze done");
      for (int s = 0; s < 4; s++)
      begin
         wr(`A_MAIN_CTRL, 1);
         cmp_raw_in <= 4'h0;
         wr(`A_EVENT_CTRL, 1);
         wr(`A_IRQ_EN, 1);
         // Filter and pin mode vary with the interrupt select.
         wr(`A_CFG0, 'h41 | (s == 3 ? 2 : 0) | s << 2 | (s % 2) * 'h80
            | (s == 1 ? 'h4000 : s == 2 ? 'h8000 : 0));
         wr(`A_MAIN_CTRL, 2);
         ev_seen = 6'h00;
         cmp_raw_in <= 4'h1;
         if (s == 3)
            wr(`A_START, 1);
         tick(s == 3 ? 230 : 12);
         check("irq_rise", irq_out, s != 2);
         check("ev_rise", ev_seen[0], 1'b1);
         check("pin_high", {pin_oe_out[0], pin_out[0]}, 2'b11);
         rd(`A_STATUS, 'h501);
         wr(`A_IRQ_CLR, 1);
         check("irq_clr", irq_out, 1'b0);
         if (s < 3)
         begin
            cmp_raw_in <= 4'h0;
            tick(12);
            check("irq_fall", irq_out, s != 1);
            check("pin_low", pin_out[0], 1'b0);
            wr(`A_IRQ_EN, 0);
            check("irq_mask", irq_out, 1'b0);
         end
      end
      $display("test interrupt done");
      for (int w = 0; w < 4; w++)
      begin
         wr(`A_MAIN_CTRL, 1);
         for (int n = 0; n < 4; n++)
            wr(`A_CFG0 + 4 * n, 1);
         wr(`A_EVENT_CTRL, 'h30);
         // Both pairs watch for the same region.
         wr(`A_WINCTRL, (1 | w << 1) * 'h11);
         wr(`A_IRQ_EN, 'h30);
         cmp_raw_in <= 4'hf;
         wr(`A_MAIN_CTRL, 2);
         tick(12);
         rd(`A_STATUS, 'h00f);
         wr(`A_IRQ_CLR, 'h30);
         for (int k = 1; k < 3; k++)
         begin
            ev_seen = 6'h00;
            cmp_raw_in <= k == 1 ? 4'ha : 4'h0;
            tick(12);
            rd(`A_STATUS, k == 1 ? 'h50a : 'ha00);
            check("win_irq", irq_out, k == 1 ? w == 1 : w > 1);
            check("win_ev", ev_seen[5:4], 2'b11);
            wr(`A_IRQ_CLR, 'h30);
         end
      end
      $display("test window done");
      wr(`A_MAIN_CTRL, 1);
      check("soft_reset_bit", {cmp_en_out, pin_oe_out, hyst_out, event_out, irq_out}, 0);
      regs_check;
      $display("test soft reset done");
      give_verdict;
   end

   // Watchdog sized well above the longest expected run.
   initial
   begin
      #100000;
      n_fail++;
      give_verdict;
   end
endmodule // tb_top
